//--- rtl/iod_decoder.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RQ1: split the 30-bit word into function, skip, operand, index and address fields.
// RQ2: index first, then storage read, then operand transfer, then function and skip.
// RQ3: effective address is address field plus the selected index register.
// RQ4: function codes 00 and 77 halt and light the fault indicator.
// RQ5: function field is the top six bits; codes 01 to 76 decoded.
// RQ6: skip select 0 never, 1 always, 2 auxiliary positive, 3 auxiliary negative.
// RQ7: skip select 4..7: accumulator zero, nonzero, positive, negative.
// RQ8: in repeat mode the skip test decides repeat exit.
// RQ9: operand codes 0, 4, 7 perform no storage read.
// RQ10: read codes 0 and 4 use address bits; code 4 sign-extends bit 14.
// RQ11: read codes 1, 2, 3 load low half, high half, or whole word.
// RQ12: read codes 5 and 6 load a half and sign-extend bit 14.
// RQ13: read code 7 takes the whole accumulator as operand.
// RQ14: store code 0 loads auxiliary; code 4 clears then adds into accumulator.
// RQ15: store codes 1 and 2 write low operand bits into one half.
// RQ16: store code 3 writes whole operand; code 7 writes its complement.
// RQ17: store codes 5 and 6 write complemented low bits into one half.
// RQ18: classify as read, store or replace and apply that class's table.
// RQ19: replace reads as read class; codes 0, 4, 7 undefined.
// RQ20: replace writes uncomplemented low bits: 1,5 low, 2,6 high, 3 whole.
// RQ21: replace code 3 reads whole word and writes it back to same address.
// RQ22: index add is ones'-complement end-around; select zero means no add.
// RQ23: sign bit one means negative, zero means positive.
module iod_decoder
	import iod_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic start,
	input wire logic [WORD_W-1:0] instrWord,
	input wire logic [IDX_N*HALF_W-1:0] idxRegs,
	input wire logic [WORD_W-1:0] accIn,
	input wire logic [WORD_W-1:0] auxIn,
	input wire logic repeatMode,
	input wire logic [WORD_W-1:0] storeVal,
	input wire logic resultValid,
	input wire logic [WORD_W-1:0] resultVal,
	input wire logic [WORD_W-1:0] memRdata,
	input wire logic memAck,
	output iod_fields_t fields,
	output logic [HALF_W-1:0] effAddr,
	output logic [WORD_W-1:0] operand,
	output logic operandValid,
	output iod_mem_t mem,
	output logic accLoad,
	output logic auxLoad,
	output logic [WORD_W-1:0] loadVal,
	output logic skipNext,
	output logic repeatExit,
	output logic done,
	output logic busy,
	output logic faultLamp,
	output logic undefOp
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// end-around carry keeps the sum zero only when both inputs are zero
	function automatic logic [HALF_W-1:0] ocAdd(input logic [HALF_W-1:0] a,
		input logic [HALF_W-1:0] b);
		logic [HALF_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[HALF_W-1:0] + {{(HALF_W-1){1'b0}}, s[HALF_W]}; // see RQ22
	endfunction

	function automatic logic [WORD_W-1:0] extHalf(input logic [HALF_W-1:0] h,
		input logic sx);
		return {(sx && h[HALF_SIGN_BIT]) ? HALF_ONES : ~HALF_ONES, h};
	endfunction

	function automatic iod_class_t classOf(input logic [F_W-1:0] f);
		case (f) // see RQ5
			6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h27: return CLS_STORE;
			6'h14, 6'h15, 6'h1C, 6'h1D, 6'h1E, 6'h1F,
			6'h24, 6'h25, 6'h26, 6'h2C, 6'h2D, 6'h2E, 6'h2F: return CLS_REPLACE;
			default: return CLS_READ;
		endcase
	endfunction

	function automatic logic immOp(input logic [K_W-1:0] k);
		return (k == K_IMM) || (k == K_IMM_SX) || (k == K_ACC);
	endfunction

	function automatic logic skipTest(input logic [J_W-1:0] j,
		input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] q);
		case (j)
			J_NEVER: return 1'b0;
			J_ALWAYS: return 1'b1;
			J_AUX_POS: return !q[SIGN_BIT]; // see RQ23
			J_AUX_NEG: return q[SIGN_BIT];
			J_ACC_ZERO: return a == WORD_ZERO; // see RQ7
			J_ACC_NZ: return a != WORD_ZERO;
			J_ACC_POS: return !a[SIGN_BIT];
			default: return a[SIGN_BIT];
		endcase
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	iod_state_t state_r, state_nxt;
	iod_fields_t u_r, u_nxt;
	iod_mem_t mem_r, mem_nxt;
	logic [HALF_W-1:0] effAddr_r, effAddr_nxt;
	logic [WORD_W-1:0] zBuf_r, zBuf_nxt;
	logic [WORD_W-1:0] opnd_r, opnd_nxt;
	logic [WORD_W-1:0] loadVal_r, loadVal_nxt;
	logic opndValid_r, opndValid_nxt;
	logic accLoad_r, accLoad_nxt;
	logic auxLoad_r, auxLoad_nxt;
	logic skip_r, skip_nxt;
	logic repExit_r, repExit_nxt;
	logic done_r, done_nxt;
	logic fault_r, fault_nxt;
	logic undef_r, undef_nxt;
	logic busy_r, busy_nxt;
	iod_class_t cls;
	logic [HALF_W-1:0] idxVal;

	assign cls = classOf(u_r.func); // see RQ18
	assign idxVal = idxRegs[(u_r.idxSel - 3'h1) * HALF_W +: HALF_W];

	always_comb
	begin
		state_nxt = state_r;
		u_nxt = u_r;
		mem_nxt = mem_r;
		effAddr_nxt = effAddr_r;
		zBuf_nxt = zBuf_r;
		opnd_nxt = opnd_r;
		loadVal_nxt = loadVal_r;
		opndValid_nxt = 1'b0;
		accLoad_nxt = 1'b0;
		auxLoad_nxt = 1'b0;
		skip_nxt = 1'b0;
		repExit_nxt = 1'b0;
		done_nxt = 1'b0;
		fault_nxt = fault_r;
		undef_nxt = 1'b0;
		busy_nxt = busy_r;
		case (state_r)
			ST_IDLE:
				if (start)
				begin
					u_nxt = instrWord; // see RQ1
					state_nxt = ST_INDEX;
				end
			ST_INDEX:
			begin
				// address is formed before anything else acts
				effAddr_nxt = (u_r.idxSel == IDX_NONE) ? u_r.addr : ocAdd(u_r.addr, idxVal); // see RQ3
				if (u_r.func == FN_FAULT_ZERO || u_r.func == FN_FAULT_ONES)
				begin
					fault_nxt = 1'b1; // see RQ4
					state_nxt = ST_FAULT;
				end
				else if (cls == CLS_REPLACE && immOp(u_r.opSel))
				begin
					undef_nxt = 1'b1; // see RQ19
					state_nxt = ST_FINISH;
				end
				else if (cls == CLS_STORE || immOp(u_r.opSel))
					state_nxt = ST_XFER; // see RQ9
				else
				begin
					mem_nxt.req = 1'b1; // see RQ2
					mem_nxt.we = 1'b0;
					mem_nxt.addr = effAddr_nxt;
					state_nxt = ST_READ;
				end
			end
			ST_READ:
				if (memAck)
				begin
					mem_nxt.req = 1'b0;
					zBuf_nxt = memRdata;
					state_nxt = ST_XFER;
				end
			ST_XFER:
			begin
				opndValid_nxt = 1'b1;
				if (cls == CLS_STORE)
				begin
					opnd_nxt = storeVal;
					state_nxt = ST_WRITE;
				end
				else
				begin
					case (u_r.opSel)
						K_IMM: opnd_nxt = extHalf(u_r.addr, 1'b0); // see RQ10
						K_IMM_SX: opnd_nxt = extHalf(u_r.addr, 1'b1); // see RQ10
						K_LO: opnd_nxt = extHalf(zBuf_r[HALF_W-1:0], 1'b0); // see RQ11
						K_HI: opnd_nxt = extHalf(zBuf_r[WORD_W-1:HALF_W], 1'b0); // see RQ11
						K_FULL: opnd_nxt = zBuf_r; // see RQ11
						K_LO_SX: opnd_nxt = extHalf(zBuf_r[HALF_W-1:0], 1'b1); // see RQ12
						K_HI_SX: opnd_nxt = extHalf(zBuf_r[WORD_W-1:HALF_W], 1'b1); // see RQ12
						default: opnd_nxt = accIn; // see RQ13
					endcase
					state_nxt = (cls == CLS_REPLACE) ? ST_EXEC : ST_FINISH;
				end
			end
			ST_EXEC:
				// replace waits for the function's result before writing it back
				if (resultValid)
				begin
					opnd_nxt = resultVal;
					state_nxt = ST_WRITE;
				end
			ST_WRITE:
				if (mem_r.req)
				begin
					if (memAck)
					begin
						mem_nxt.req = 1'b0;
						mem_nxt.we = 1'b0;
						state_nxt = ST_FINISH;
					end
				end
				else if (cls == CLS_STORE && u_r.opSel == K_IMM)
				begin
					auxLoad_nxt = 1'b1; // see RQ14
					loadVal_nxt = opnd_r;
					state_nxt = ST_FINISH;
				end
				else if (cls == CLS_STORE && u_r.opSel == K_IMM_SX)
				begin
					accLoad_nxt = 1'b1; // see RQ14
					loadVal_nxt = opnd_r;
					state_nxt = ST_FINISH;
				end
				else
				begin
					mem_nxt.req = 1'b1;
					mem_nxt.we = 1'b1;
					mem_nxt.addr = effAddr_r; // see RQ21
					case (u_r.opSel)
						K_LO, K_LO_SX: mem_nxt.halfEn = HALF_LO;
						K_HI, K_HI_SX: mem_nxt.halfEn = HALF_HI;
						default: mem_nxt.halfEn = HALF_BOTH;
					endcase
					if (cls == CLS_STORE && (u_r.opSel == K_LO_SX || u_r.opSel == K_HI_SX))
						mem_nxt.wdata = {~opnd_r[HALF_W-1:0], ~opnd_r[HALF_W-1:0]}; // see RQ17
					else if (cls == CLS_STORE && u_r.opSel == K_ACC)
						mem_nxt.wdata = ~opnd_r; // see RQ16
					else if (u_r.opSel == K_FULL || u_r.opSel == K_ACC)
						mem_nxt.wdata = opnd_r; // see RQ16
					else
						mem_nxt.wdata = {opnd_r[HALF_W-1:0], opnd_r[HALF_W-1:0]}; // see RQ15, RQ20
				end
			ST_FINISH:
			begin
				// accumulator and auxiliary are sampled now; only replace waits for resultValid first, read and store classes do not
				skip_nxt = skipTest(u_r.skipSel, accIn, auxIn); // see RQ6
				repExit_nxt = repeatMode && skipTest(u_r.skipSel, accIn, auxIn); // see RQ8
				done_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
			ST_FAULT:
				state_nxt = ST_FAULT; // only reset restarts computation
			default:
				state_nxt = ST_IDLE;
		endcase
		// registered so that busy comes straight from a flip-flop
		busy_nxt = (state_nxt != ST_IDLE);
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= ST_IDLE;
			u_r <= '0;
			mem_r <= '0;
			effAddr_r <= '0;
			zBuf_r <= '0;
			opnd_r <= '0;
			loadVal_r <= '0;
			opndValid_r <= 1'b0;
			accLoad_r <= 1'b0;
			auxLoad_r <= 1'b0;
			skip_r <= 1'b0;
			repExit_r <= 1'b0;
			done_r <= 1'b0;
			fault_r <= 1'b0;
			undef_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else if (clkEn)
		begin
			state_r <= state_nxt;
			u_r <= u_nxt;
			mem_r <= mem_nxt;
			effAddr_r <= effAddr_nxt;
			zBuf_r <= zBuf_nxt;
			opnd_r <= opnd_nxt;
			loadVal_r <= loadVal_nxt;
			opndValid_r <= opndValid_nxt;
			accLoad_r <= accLoad_nxt;
			auxLoad_r <= auxLoad_nxt;
			skip_r <= skip_nxt;
			repExit_r <= repExit_nxt;
			done_r <= done_nxt;
			fault_r <= fault_nxt;
			undef_r <= undef_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign fields = u_r;
	assign effAddr = effAddr_r;
	assign operand = opnd_r;
	assign operandValid = opndValid_r;
	assign mem = mem_r;
	assign accLoad = accLoad_r;
	assign auxLoad = auxLoad_r;
	assign loadVal = loadVal_r;
	assign skipNext = skip_r;
	assign repeatExit = repExit_r;
	assign done = done_r;
	assign busy = busy_r;
	assign faultLamp = fault_r;
	assign undefOp = undef_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_faultCode;
		@(posedge mclk) disable iff (!rst_b)
		(clkEn && state_r == ST_INDEX && (u_r.func == FN_FAULT_ZERO || u_r.func == FN_FAULT_ONES))
		|=> fault_r && state_r == ST_FAULT;
	endproperty
	a_faultCode: assert property (p_faultCode) else $error("fault code not trapped"); // see RQ4

	property p_noImmRead;
		@(posedge mclk) disable iff (!rst_b)
		(state_r == ST_READ) |-> !immOp(u_r.opSel) && cls != CLS_STORE;
	endproperty
	a_noImmRead: assert property (p_noImmRead) else $error("storage read for immediate operand"); // see RQ9

	property p_idxNone;
		@(posedge mclk) disable iff (!rst_b)
		(clkEn && state_r == ST_INDEX && u_r.idxSel == IDX_NONE) |=> effAddr_r == $past(u_r.addr);
	endproperty
	a_idxNone: assert property (p_idxNone) else $error("address modified with no index"); // see RQ22

	property p_idxNonZero;
		@(posedge mclk) disable iff (!rst_b)
		(clkEn && state_r == ST_INDEX && u_r.idxSel != IDX_NONE && (u_r.addr != '0 || idxVal != '0))
		|=> effAddr_r != '0;
	endproperty
	a_idxNonZero: assert property (p_idxNonZero) else $error("index add gave zero"); // see RQ3

	property p_sxHalf;
		@(posedge mclk) disable iff (!rst_b)
		(clkEn && state_r == ST_XFER && cls == CLS_READ && u_r.opSel == K_LO_SX && zBuf_r[HALF_SIGN_BIT])
		|=> opnd_r[WORD_W-1:HALF_W] == HALF_ONES && opndValid_r;
	endproperty
	a_sxHalf: assert property (p_sxHalf) else $error("half not sign extended"); // see RQ12

	property p_accOperand;
		@(posedge mclk) disable iff (!rst_b)
		(clkEn && state_r == ST_XFER && cls == CLS_READ && u_r.opSel == K_ACC)
		|=> opnd_r == $past(accIn);
	endproperty
	a_accOperand: assert property (p_accOperand) else $error("accumulator operand wrong"); // see RQ13

	property p_skipAlways;
		@(posedge mclk) disable iff (!rst_b)
		(clkEn && state_r == ST_FINISH && u_r.skipSel == J_ALWAYS) |=> skipNext && done ##1 !done;
	endproperty
	a_skipAlways: assert property (p_skipAlways) else $error("unconditional skip missed"); // see RQ6

	property p_skipAccZero;
		@(posedge mclk) disable iff (!rst_b)
		(clkEn && state_r == ST_FINISH && u_r.skipSel == J_ACC_ZERO) |=> skipNext == ($past(accIn) == '0);
	endproperty
	a_skipAccZero: assert property (p_skipAccZero) else $error("accumulator zero skip wrong"); // see RQ7

	property p_storeCompl;
		@(posedge mclk) disable iff (!rst_b)
		(mem_r.req && mem_r.we && cls == CLS_STORE && u_r.opSel == K_LO_SX)
		|-> mem_r.wdata[HALF_W-1:0] == ~opnd_r[HALF_W-1:0] && mem_r.halfEn == HALF_LO;
	endproperty
	a_storeCompl: assert property (p_storeCompl) else $error("complemented half store wrong"); // see RQ17

	property p_replaceBack;
		@(posedge mclk) disable iff (!rst_b)
		(mem_r.req && mem_r.we && cls == CLS_REPLACE) |-> mem_r.addr == effAddr_r
		&& (u_r.opSel != K_FULL || (mem_r.wdata == opnd_r && mem_r.halfEn == HALF_BOTH));
	endproperty
	a_replaceBack: assert property (p_replaceBack) else $error("replace write-back wrong"); // see RQ21
endmodule // iod_decoder

`default_nettype wire

//--- rtl/iod_pkg.sv
package iod_pkg;
	// ------------------------------------------------------------
	// word layout
	// ------------------------------------------------------------
	localparam int WORD_W = 30;
	localparam int HALF_W = 15;
	localparam int F_W = 6;
	localparam int J_W = 3;
	localparam int K_W = 3;
	localparam int B_W = 3;
	localparam int IDX_N = 7;
	localparam int SIGN_BIT = 29;
	localparam int HALF_SIGN_BIT = 14;
	localparam logic [F_W-1:0] FN_FAULT_ZERO = 6'h00;
	localparam logic [F_W-1:0] FN_FAULT_ONES = 6'h3F;
	localparam logic [B_W-1:0] IDX_NONE = 3'h0;
	localparam logic [1:0] HALF_LO = 2'h1;
	localparam logic [1:0] HALF_HI = 2'h2;
	localparam logic [1:0] HALF_BOTH = 2'h3;
	localparam logic [HALF_W-1:0] HALF_ONES = 15'h7FFF;
	localparam logic [WORD_W-1:0] WORD_ZERO = 30'h0;

	// operand interpretation codes
	localparam logic [K_W-1:0] K_IMM = 3'h0;
	localparam logic [K_W-1:0] K_LO = 3'h1;
	localparam logic [K_W-1:0] K_HI = 3'h2;
	localparam logic [K_W-1:0] K_FULL = 3'h3;
	localparam logic [K_W-1:0] K_IMM_SX = 3'h4;
	localparam logic [K_W-1:0] K_LO_SX = 3'h5;
	localparam logic [K_W-1:0] K_HI_SX = 3'h6;
	localparam logic [K_W-1:0] K_ACC = 3'h7;

	// skip condition codes
	localparam logic [J_W-1:0] J_NEVER = 3'h0;
	localparam logic [J_W-1:0] J_ALWAYS = 3'h1;
	localparam logic [J_W-1:0] J_AUX_POS = 3'h2;
	localparam logic [J_W-1:0] J_AUX_NEG = 3'h3;
	localparam logic [J_W-1:0] J_ACC_ZERO = 3'h4;
	localparam logic [J_W-1:0] J_ACC_NZ = 3'h5;
	localparam logic [J_W-1:0] J_ACC_POS = 3'h6;
	localparam logic [J_W-1:0] J_ACC_NEG = 3'h7;

	typedef enum logic [1:0] {CLS_READ = 2'h0, CLS_STORE = 2'h1, CLS_REPLACE = 2'h2} iod_class_t;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_INDEX = 8'h02,
		ST_READ = 8'h04,
		ST_XFER = 8'h08,
		ST_EXEC = 8'h10,
		ST_WRITE = 8'h20,
		ST_FINISH = 8'h40,
		ST_FAULT = 8'h80
	} iod_state_t;

	typedef struct packed {
		logic [F_W-1:0] func;
		logic [J_W-1:0] skipSel;
		logic [K_W-1:0] opSel;
		logic [B_W-1:0] idxSel;
		logic [HALF_W-1:0] addr;
	} iod_fields_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [HALF_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
		logic [1:0] halfEn;
	} iod_mem_t;
endpackage

//--- tb/iod_storage_model.sv
`timescale 1ns/10ps
`default_nettype none
module iod_storage_model
	import iod_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic slow,
	input wire iod_mem_t mem,
	output logic [WORD_W-1:0] memRdata,
	output logic memAck
);
	// sixteen words are enough: only the low address bits select a cell
	logic [WORD_W-1:0] cells [0:15];
	logic [1:0] waitCnt;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			memAck <= 1'b0;
			memRdata <= 30'h0000_0000;
			waitCnt <= 2'h0;
		end
		else if (mem.req && !memAck && (waitCnt == 2'h3 || !slow))
		begin
			memAck <= 1'b1;
			waitCnt <= 2'h0;
			memRdata <= cells[mem.addr[3:0]];
			if (mem.we && mem.halfEn[0])
				cells[mem.addr[3:0]][14:0] <= mem.wdata[14:0];
			if (mem.we && mem.halfEn[1])
				cells[mem.addr[3:0]][29:15] <= mem.wdata[29:15];
		end
		else
		begin
			memAck <= 1'b0;
			waitCnt <= (mem.req && !memAck) ? waitCnt + 2'h1 : 2'h0;
			// data is gone after the ack: a late sample sees garbage
			memRdata <= ~memRdata;
		end
	end
endmodule // iod_storage_model
`default_nettype wire

//--- tb/instruction_operand_decoder_test.sv
`timescale 1ns/10ps
`default_nettype none
module instruction_operand_decoder_test
	import iod_pkg::*;
;
	logic mclk = 1'b0;
	logic rstB, clkEn, start, repeatMode, resultValid, memAck, slow;
	logic [WORD_W-1:0] instrWord, accIn, auxIn, storeVal, resultVal, memRdata;
	logic [IDX_N*HALF_W-1:0] idxRegs;
	iod_fields_t fields;
	iod_mem_t mem;
	logic [HALF_W-1:0] effAddr, gotAddr;
	logic [WORD_W-1:0] operand, loadVal, gotOpnd, gotLoad;
	logic operandValid, accLoad, auxLoad, skipNext, repeatExit, done, busy, faultLamp, undefOp;
	logic gotDone, gotSkip, gotExit, gotAcc, gotAux, gotUndef, gotReq;
	int nErrors = 0;
	int testsRun = 0;

	always #50 mclk = ~mclk;

	iod_decoder u_dut (.mclk(mclk), .rst_b(rstB), .clkEn(clkEn), .start(start),
		.instrWord(instrWord), .idxRegs(idxRegs), .accIn(accIn), .auxIn(auxIn),
		.repeatMode(repeatMode), .storeVal(storeVal), .resultValid(resultValid),
		.resultVal(resultVal), .memRdata(memRdata), .memAck(memAck), .fields(fields),
		.effAddr(effAddr), .operand(operand), .operandValid(operandValid), .mem(mem),
		.accLoad(accLoad), .auxLoad(auxLoad), .loadVal(loadVal), .skipNext(skipNext),
		.repeatExit(repeatExit), .done(done), .busy(busy), .faultLamp(faultLamp),
		.undefOp(undefOp));

	iod_storage_model u_store (.mclk(mclk), .rst_b(rstB), .slow(slow), .mem(mem),
		.memRdata(memRdata), .memAck(memAck));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [WORD_W-1:0] exp,
		input logic [WORD_W-1:0] got);
		testsRun++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			nErrors++;
		end
	endtask

	// runs one instruction and records every pulse; a missing done is left to the caller
	task automatic exec(input logic [WORD_W-1:0] iw);
		int i;
		{gotDone, gotSkip, gotExit, gotAcc, gotAux, gotUndef, gotReq} = 7'h00;
		gotOpnd = {WORD_W{1'bx}};
		gotLoad = {WORD_W{1'bx}};
		gotAddr = 15'h7FFF;
		resultValid = 1'b0;
		@(negedge mclk);
		instrWord = iw;
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		for (i = 0; i < 40 && !gotDone; i++)
		begin
			if (operandValid === 1'b1)
			begin
				gotOpnd = operand;
				resultValid = 1'b1;
			end
			if (mem.req === 1'b1)
			begin
				gotReq = 1'b1;
				gotAddr = mem.addr;
			end
			if (accLoad === 1'b1 || auxLoad === 1'b1)
				gotLoad = loadVal;
			gotAcc |= accLoad === 1'b1;
			gotAux |= auxLoad === 1'b1;
			gotUndef |= undefOp === 1'b1;
			if (done === 1'b1)
			begin
				gotDone = 1'b1;
				gotSkip = skipNext;
				gotExit = repeatExit;
			end
			else
				@(negedge mclk);
		end
	endtask

	function automatic logic [WORD_W-1:0] readExp(input int k, input logic [WORD_W-1:0] w);
		case (k)
			0: return {15'h0000, 15'h4003};
			1: return {15'h0000, w[14:0]};
			2: return {15'h0000, w[29:15]};
			3: return w;
			4: return 30'h3FFF_C003;
			5: return {{15{w[14]}}, w[14:0]};
			6: return {{15{w[29]}}, w[29:15]};
			default: return accIn;
		endcase
	endfunction

	function automatic logic skipExp(input int j, input logic [WORD_W-1:0] a,
		input logic [WORD_W-1:0] q);
		case (j)
			0: return 1'b0;
			1: return 1'b1;
			2: return !q[29];
			3: return q[29];
			4: return a == 30'h0000_0000;
			5: return a != 30'h0000_0000;
			6: return !a[29];
			default: return a[29];
		endcase
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_read;
		logic [WORD_W-1:0] iw;
		int k;
		u_store.cells[4] = 30'h2345_6789;
		for (k = 0; k < 8; k++)
		begin
			if (k == 0 || k == 4 || k == 7)
				iw = {6'h10, 3'h0, 3'(k), 3'h0, 15'h4003};
			else
				iw = {6'h10, 3'h0, 3'(k), 3'h3, 15'h0005};
			exec(iw);
			chk("fields", iw, fields);
			chk("operand", readExp(k, 30'h2345_6789), gotOpnd);
			chk("storage read", 30'(!(k == 0 || k == 4 || k == 7)), 30'(gotReq));
			chk("effective address", (iw[17:15] == 3'h3) ? 30'h4 : 30'h4003, 30'(effAddr));
			chk("busy after done", 30'h0, 30'(busy));
			if (iw[17:15] == 3'h3)
				chk("address", 30'h0000_0004, 30'(gotAddr));
		end
	endtask

	task automatic t_skip;
		int p, j;
		for (p = 0; p < 3; p++)
		begin
			accIn = (p == 0) ? 30'h0000_0000 : (p == 1) ? 30'h2000_0001 : 30'h0000_0001;
			auxIn = (p == 0) ? 30'h0000_0000 : 30'h2000_0000;
			repeatMode = (p != 0);
			for (j = 0; j < 8; j++)
			begin
				exec({6'h10, 3'(j), 3'h0, 3'h0, 15'h0000});
				chk("done", 30'h1, 30'(gotDone));
				chk("skip", 30'(skipExp(j, accIn, auxIn)), 30'(gotSkip));
				chk("repeat exit", 30'(repeatMode & skipExp(j, accIn, auxIn)), 30'(gotExit));
			end
		end
		repeatMode = 1'b0;
	endtask

	task automatic t_store;
		logic [WORD_W-1:0] pre, v, ex;
		int k;
		pre = 30'h0F0F_0F0F;
		v = 30'h1ABC_4321;
		storeVal = v;
		slow = 1'b1;
		for (k = 0; k < 8; k++)
		begin
			u_store.cells[9] = pre;
			exec({6'h0D, 3'h0, 3'(k), 3'h0, 15'h0009});
			case (k)
				1: ex = {pre[29:15], v[14:0]};
				2: ex = {v[14:0], pre[14:0]};
				3: ex = v;
				5: ex = {pre[29:15], ~v[14:0]};
				6: ex = {~v[14:0], pre[14:0]};
				7: ex = ~v;
				default: ex = pre;
			endcase
			chk("stored word", ex, u_store.cells[9]);
			chk("aux load", 30'(k == 0), 30'(gotAux));
			chk("acc load", 30'(k == 4), 30'(gotAcc));
			if (k == 0 || k == 4)
				chk("load value", v, gotLoad);
		end
	endtask

	task automatic t_replace;
		logic [WORD_W-1:0] w, r, ex;
		int k;
		w = 30'h2345_6789;
		r = 30'h2468_ACE1;
		resultVal = r;
		for (k = 0; k < 8; k++)
		begin
			u_store.cells[9] = w;
			slow = k[0];
			exec({6'h14, 3'h0, 3'(k), 3'h0, 15'h0009});
			case (k)
				1, 5: ex = {w[29:15], r[14:0]};
				2, 6: ex = {r[14:0], w[14:0]};
				3: ex = r;
				default: ex = w;
			endcase
			chk("replaced word", ex, u_store.cells[9]);
			chk("undefined code", 30'(k == 0 || k == 4 || k == 7), 30'(gotUndef));
			chk("done", 30'h1, 30'(gotDone));
			if (!(k == 0 || k == 4 || k == 7))
				chk("read portion", readExp(k, w), gotOpnd);
		end
	endtask

	task automatic t_fault;
		int n;
		for (n = 0; n < 2; n++)
		begin
			exec({n ? FN_FAULT_ONES : FN_FAULT_ZERO, 24'h000000});
			chk("fault done", 30'h0, 30'(gotDone));
			chk("fault lamp", 30'h1, 30'(faultLamp));
			exec({6'h10, 3'h0, 3'h3, 3'h0, 15'h0004});
			chk("after fault", 30'h0, 30'(gotDone | gotReq));
			rstB = 1'b0;
			@(negedge mclk);
			@(negedge mclk);
			rstB = 1'b1;
			chk("lamp cleared", 30'h0, 30'(faultLamp));
		end
	endtask

	task automatic wrap_up;
		$display("errors %0d checks %0d", nErrors, testsRun);
		if (nErrors == 0 && testsRun > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#500000;
		nErrors++;
		wrap_up;
	end

	initial
	begin
		rstB = 1'b0;
		{clkEn, start, repeatMode, resultValid, slow} = 5'h10;
		instrWord = 30'h0000_0000;
		accIn = 30'h1357_9BDF;
		auxIn = 30'h0000_0000;
		storeVal = 30'h0000_0000;
		resultVal = 30'h0000_0000;
		idxRegs = {IDX_N*HALF_W{1'b0}};
		idxRegs[2*HALF_W +: HALF_W] = 15'h7FFE;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rstB = 1'b1;
		t_read;
		t_skip;
		t_store;
		t_replace;
		t_fault;
		wrap_up;
	end
endmodule // instruction_operand_decoder_test
`default_nettype wire
